/* File: logic/serial_async_baud_and_frame.sv */
// Asynchronous serial transmitter/receiver with modulo baud generator and APB registers
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module serial_async_baud_and_frame
	import uart_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        rxd_i,
	output logic             txd_o,
	output logic             break_irq_o,
	output logic             edge_irq_o
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [7:0]  bdh_ff, bdl_ff, ctrl1_ff, ctrl2_ff;
	logic [4:0]  hi_buf_ff;
	logic        armed_ff;
	logic [12:0] baud_cnt_ff;
	logic        tick_ff;
	logic [12:0] divisor;
	status_t     stat_ff, st_set, st_clr;
	logic [31:0] prdata_ff, rd_mux;
	logic        mapped, wr_acc, rd_acc;
	logic [8:0]  tx_hold_ff, rx_data_ff;
	tx_state_t   tx_state_ff;
	logic [3:0]  tx_sub_ff, tx_bits_ff;
	logic [10:0] tx_shift_ff;
	logic        txd_ff, tx_load, tx_brk_load, tx_end;
	logic        rx_s1_ff, rx_s2_ff, rx_s3_ff, rx_line_ff, rx_prev_ff;
	rx_state_t   rx_state_ff;
	logic [3:0]  rx_sub_ff, rx_bits_ff;
	logic [2:0]  rx_smp_ff;
	logic [8:0]  rx_shift_ff;
	logic        rx_noise_ff, rx_fall, bit_val, bit_noisy, rx_done;
	logic [8:0]  rx_char;
	logic        rx_accept, idle_evt, brk_evt;
	logic [7:0]  idle_cnt_ff, brk_cnt_ff;
	logic        idle_armed_ff, brk_seen_ff;
	logic        brk_irq_ff, edge_irq_ff;
	logic        nine, rx_en;
	logic [3:0]  n_bits;

	// Majority of three samples
	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// Replace the character's top bit with the parity bit
	function automatic logic [8:0] add_par(input logic [8:0] d, input logic nb,
		input logic pe, input logic odd);
		logic [8:0] r;
		r = d;
		if (pe && nb) begin
			r[8] = (^d[7:0]) ^ odd;
		end else if (pe) begin
			r[7] = (^d[6:0]) ^ odd;
			r[8] = 1'b0;
		end
		add_par = r;
	endfunction

	assign nine     = ctrl1_ff[C1_NINE];
	assign rx_en    = ctrl2_ff[C2_RX_EN];
	assign n_bits   = nine ? 4'h9 : 4'h8;
	assign divisor  = {bdh_ff[4:0], bdl_ff};

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// Zero wait states; unmapped addresses answer with an error
	assign mapped = (paddr_i == OFF_BDH) || (paddr_i == OFF_BDL) ||
		(paddr_i == OFF_CTRL1) || (paddr_i == OFF_CTRL2) ||
		(paddr_i == OFF_STAT) || (paddr_i == OFF_DATA);
	assign wr_acc    = psel_i & penable_i & pwrite_i & mapped;
	assign rd_acc    = psel_i & penable_i & ~pwrite_i & mapped;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign prdata_o  = prdata_ff;

	// Read mux, captured in the setup phase so data comes from a flop
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (paddr_i == OFF_BDH) begin
			rd_mux[7:0] = bdh_ff;
		end else if (paddr_i == OFF_BDL) begin
			rd_mux[7:0] = bdl_ff;
		end else if (paddr_i == OFF_CTRL1) begin
			rd_mux[7:0] = ctrl1_ff;
		end else if (paddr_i == OFF_CTRL2) begin
			rd_mux[7:0] = ctrl2_ff;
		end else if (paddr_i == OFF_STAT) begin
			rd_mux[9:0] = stat_ff;
		end else if (paddr_i == OFF_DATA) begin
			rd_mux[8:0] = rx_data_ff;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_ff <= rd_mux;
		end
	end

	// ****************************************************************
	// Control and divisor registers
	// ****************************************************************
	// High half only reaches the divisor when the low half is written
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bdh_ff    <= RST_BDH;
			hi_buf_ff <= RST_BDH[4:0];
			bdl_ff    <= RST_BDL;
		end else if (wr_acc && paddr_i == OFF_BDH) begin
			bdh_ff[7:6] <= pwdata_i[7:6];
			hi_buf_ff   <= pwdata_i[4:0];
		end else if (wr_acc && paddr_i == OFF_BDL) begin
			bdl_ff       <= pwdata_i[7:0];
			bdh_ff[4:0]  <= hi_buf_ff;
		end
	end

	// Sleep bit is also cleared by a wakeup event
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ctrl1_ff <= RST_CTRL;
			ctrl2_ff <= RST_CTRL;
		end else begin
			if (wr_acc && paddr_i == OFF_CTRL1) begin
				ctrl1_ff <= {2'b00, pwdata_i[5:3], 1'b0, pwdata_i[1:0]};
			end
			if (wr_acc && paddr_i == OFF_CTRL2) begin
				ctrl2_ff <= {4'h0, pwdata_i[3:0]};
			end else if (ctrl2_ff[C2_RX_SLEEP] && (idle_evt && !ctrl1_ff[C1_WAKE_ADR] ||
				rx_done && ctrl1_ff[C1_WAKE_ADR] && rx_char[n_bits - 4'h1])) begin
				ctrl2_ff[C2_RX_SLEEP] <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Baud generator
	// ****************************************************************
	// Non-zero reset divisor would otherwise burn power before use
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			armed_ff <= 1'b0;
		end else if (wr_acc && paddr_i == OFF_CTRL2 && (pwdata_i[C2_TX_EN] || pwdata_i[C2_RX_EN])) begin
			armed_ff <= 1'b1;
		end
	end

	// One tick per divisor cycles gives sixteen ticks per bit
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !armed_ff || divisor == 13'h0000) begin
			baud_cnt_ff <= 13'h0000;
			tick_ff     <= 1'b0;
		end else if (baud_cnt_ff >= divisor - 13'h0001) begin
			baud_cnt_ff <= 13'h0000;
			tick_ff     <= 1'b1;
		end else begin
			baud_cnt_ff <= baud_cnt_ff + 13'h0001;
			tick_ff     <= 1'b0;
		end
	end

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	// Break takes priority over queued data while the send bit is set
	assign tx_brk_load = (tx_state_ff == TX_IDLE) & ctrl2_ff[C2_TX_EN] & ctrl2_ff[C2_SEND_BRK];
	assign tx_load = (tx_state_ff == TX_IDLE) & ctrl2_ff[C2_TX_EN] & ~ctrl2_ff[C2_SEND_BRK]
		& ~stat_ff.tdre & ~(wr_acc && paddr_i == OFF_DATA);
	assign tx_end = (tx_state_ff == TX_SHIFT) & tick_ff & (tx_sub_ff == OVS_LAST)
		& (tx_bits_ff == 4'h1);

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			tx_hold_ff <= 9'h000;
		end else if (wr_acc && paddr_i == OFF_DATA) begin
			tx_hold_ff <= pwdata_i[8:0];
		end
	end

	// Shift register fills with ones so the stop bit follows the data
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			tx_state_ff <= TX_IDLE;
			tx_shift_ff <= 11'h7FF;
			tx_sub_ff   <= 4'h0;
			tx_bits_ff  <= 4'h0;
		end else begin
			case (tx_state_ff)
				TX_IDLE: begin
					tx_sub_ff <= 4'h0;
					if (tx_brk_load) begin
						tx_shift_ff <= 11'h000;
						tx_bits_ff  <= TX_BRK_BITS;
						tx_state_ff <= TX_SHIFT;
					end else if (tx_load) begin
						tx_shift_ff <= {1'b1, add_par(tx_hold_ff, nine,
							ctrl1_ff[C1_PAR_EN], ctrl1_ff[C1_PAR_ODD]), 1'b0};
						if (!nine) begin
							tx_shift_ff[9] <= 1'b1;
						end
						tx_bits_ff  <= n_bits + 4'h2;
						tx_state_ff <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (tick_ff) begin
						tx_sub_ff <= tx_sub_ff + 4'h1;
						if (tx_sub_ff == OVS_LAST) begin
							tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
							tx_bits_ff  <= tx_bits_ff - 4'h1;
							if (tx_bits_ff == 4'h1) begin
								tx_state_ff <= TX_IDLE;
							end
						end
					end
				end
				default: tx_state_ff <= TX_IDLE;
			endcase
		end
	end

	// Registered pin; idle line is mark before inversion
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			txd_ff <= 1'b1;
		end else begin
			txd_ff <= ((tx_state_ff == TX_SHIFT) ? tx_shift_ff[0] : 1'b1)
				^ ctrl1_ff[C1_TX_INV];
		end
	end
	assign txd_o = txd_ff;

	// ****************************************************************
	// Receiver
	// ****************************************************************
	// Three-stage sync; line changes only once stages two and three agree
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rx_s1_ff   <= 1'b1;
			rx_s2_ff   <= 1'b1;
			rx_s3_ff   <= 1'b1;
			rx_line_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_s1_ff   <= rxd_i;
			rx_s2_ff   <= rx_s1_ff;
			rx_s3_ff   <= rx_s2_ff;
			rx_prev_ff <= rx_line_ff;
			if (rx_s2_ff == rx_s3_ff) begin
				rx_line_ff <= rx_s3_ff;
			end
		end
	end

	assign rx_fall   = rx_prev_ff & ~rx_line_ff;
	assign bit_val   = maj3(rx_smp_ff);
	assign bit_noisy = ~(&rx_smp_ff) & (|rx_smp_ff);
	assign rx_done   = (rx_state_ff == RX_STOP) & tick_ff & (rx_sub_ff == OVS_LAST);
	assign rx_char   = nine ? rx_shift_ff : {1'b0, rx_shift_ff[8:1]};
	// Asleep receivers drop characters unless an address mark wakes them
	assign rx_accept = rx_done & (~ctrl2_ff[C2_RX_SLEEP] |
		(ctrl1_ff[C1_WAKE_ADR] & rx_char[n_bits - 4'h1]));

	// Sample at ticks 7, 8, 9 of each bit, decide at tick 15
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !rx_en) begin
			rx_state_ff <= RX_IDLE;
			rx_sub_ff   <= 4'h0;
			rx_bits_ff  <= 4'h0;
			rx_smp_ff   <= 3'b111;
			rx_shift_ff <= 9'h000;
			rx_noise_ff <= 1'b0;
		end else if (rx_state_ff == RX_IDLE) begin
			rx_sub_ff <= 4'h0;
			if (rx_fall) begin
				rx_state_ff <= RX_START;
				rx_noise_ff <= 1'b0;
			end
		end else if (tick_ff) begin
			rx_sub_ff <= rx_sub_ff + 4'h1;
			if (rx_sub_ff >= SMP_FIRST && rx_sub_ff <= SMP_LAST) begin
				rx_smp_ff[2'(rx_sub_ff - SMP_FIRST)] <= rx_line_ff;
			end
			if (rx_sub_ff == OVS_LAST) begin
				rx_noise_ff <= rx_noise_ff | bit_noisy;
				case (rx_state_ff)
					RX_START: begin
						rx_bits_ff  <= 4'h0;
						rx_state_ff <= bit_val ? RX_IDLE : RX_DATA;
					end
					RX_DATA: begin
						rx_shift_ff <= {bit_val, rx_shift_ff[8:1]};
						rx_bits_ff  <= rx_bits_ff + 4'h1;
						if (rx_bits_ff == n_bits - 4'h1) begin
							rx_state_ff <= RX_STOP;
						end
					end
					default: rx_state_ff <= RX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rx_data_ff <= 9'h000;
		end else if (rx_accept && !stat_ff.rdrf) begin
			rx_data_ff <= rx_char;
		end
	end

	// Idle needs a full character of mark after activity; break needs 11 bits of space
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !rx_en) begin
			idle_cnt_ff   <= 8'h00;
			brk_cnt_ff    <= 8'h00;
			idle_armed_ff <= 1'b0;
			brk_seen_ff   <= 1'b0;
		end else begin
			if (rx_fall) begin
				idle_armed_ff <= 1'b1;
			end else if (idle_evt) begin
				idle_armed_ff <= 1'b0;
			end
			if (!rx_line_ff) begin
				idle_cnt_ff <= 8'h00;
			end else if (tick_ff && idle_cnt_ff != 8'hFF) begin
				idle_cnt_ff <= idle_cnt_ff + 8'h01;
			end
			if (rx_line_ff) begin
				brk_cnt_ff  <= 8'h00;
				brk_seen_ff <= 1'b0;
			end else if (tick_ff && brk_cnt_ff != RX_BRK_TKS) begin
				brk_cnt_ff <= brk_cnt_ff + 8'h01;
			end else if (brk_evt) begin
				brk_seen_ff <= 1'b1;
			end
		end
	end
	assign idle_evt = idle_armed_ff & (idle_cnt_ff == (nine ? IDLE9_TKS : IDLE8_TKS));
	assign brk_evt  = (brk_cnt_ff == RX_BRK_TKS) & ~brk_seen_ff;

	// ****************************************************************
	// Status flags
	// ****************************************************************
	// Hardware sets win over software clears in the same cycle
	always_comb begin
		st_set            = '0;
		st_clr            = '0;
		st_set.tdre       = tx_load;
		st_set.tc         = tx_end & stat_ff.tdre;
		st_set.rdrf       = rx_accept & ~stat_ff.rdrf;
		st_set.overrun    = rx_accept & stat_ff.rdrf;
		st_set.noise      = rx_accept & (rx_noise_ff | bit_noisy);
		st_set.framing    = rx_accept & ~bit_val;
		st_set.parity_err = rx_accept & ctrl1_ff[C1_PAR_EN] &
			((nine ? ^rx_char[8:0] : ^rx_char[7:0]) != ctrl1_ff[C1_PAR_ODD]);
		st_set.idle       = idle_evt;
		st_set.rx_edge    = rx_fall & rx_en;
		st_set.line_break = brk_evt;
		if (wr_acc && paddr_i == OFF_STAT) begin
			st_clr = pwdata_i[9:0];
			st_clr.tdre = 1'b0;
			st_clr.rdrf = 1'b0;
		end
		if (wr_acc && paddr_i == OFF_DATA) begin
			st_clr.tdre = 1'b1;
			st_clr.tc   = 1'b1;
		end
		if (rd_acc && paddr_i == OFF_DATA) begin
			st_clr.rdrf = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			stat_ff      <= '0;
			stat_ff.tdre <= 1'b1;
			stat_ff.tc   <= 1'b1;
		end else begin
			stat_ff <= (stat_ff & ~st_clr) | st_set;
		end
	end

	// Flag-driven requests gated by the enables in the high divisor byte
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			brk_irq_ff  <= 1'b0;
			edge_irq_ff <= 1'b0;
		end else begin
			brk_irq_ff  <= stat_ff.line_break & bdh_ff[BDH_BRK_IE];
			edge_irq_ff <= stat_ff.rx_edge & bdh_ff[BDH_EDGE_IE];
		end
	end
	assign break_irq_o = brk_irq_ff;
	assign edge_irq_o  = edge_irq_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_zero_stops: assert property (divisor == 13'h0000 |=> !tick_ff)
		else $error("baud tick with zero divisor");
	chk_idle_reset: assert property (!armed_ff |-> !tick_ff)
		else $error("baud tick before enable written");
	chk_hi_buffered: assert property ((wr_acc && paddr_i == OFF_BDH) |=> $stable(bdh_ff[4:0]))
		else $error("high write changed working divisor");
	chk_lo_commit: assert property ((wr_acc && paddr_i == OFF_BDL) |=> bdh_ff[4:0] == $past(hi_buf_ff))
		else $error("low write did not commit high half");
	chk_tick_period: assert property ((tick_ff && divisor == 13'h0002 && !wr_acc) |=> !tick_ff ##1 tick_ff)
		else $error("baud period wrong for divisor two");
	chk_brk_gate: assert property (!bdh_ff[BDH_BRK_IE] |=> !break_irq_o)
		else $error("break request while disabled");
	chk_edge_gate: assert property ((stat_ff.rx_edge && bdh_ff[BDH_EDGE_IE]) |=> edge_irq_o)
		else $error("edge request missing");
	chk_start_bit: assert property ((tx_load && !wr_acc) |=> ##1 (txd_o == ctrl1_ff[C1_TX_INV]))
		else $error("start bit not driven after load");
	chk_tdre_load: assert property (tx_load |=> stat_ff.tdre)
		else $error("empty flag not set on load");
	chk_overrun: assert property ((rx_accept && stat_ff.rdrf) |=> stat_ff.overrun)
		else $error("overrun not flagged");
	chk_tx_idle_line: assert property (!ctrl2_ff[C2_TX_EN] && tx_state_ff == TX_IDLE && !wr_acc |=> txd_o == $past(ctrl1_ff[C1_TX_INV]) ^ 1'b1)
		else $error("idle line level wrong");

	cov_break_sent: cover property (tx_brk_load ##[1:1000] tx_end);
	cov_rx_char: cover property (rx_accept && !stat_ff.rdrf);
	cov_overrun: cover property (st_set.overrun);
	cov_line_break: cover property (brk_evt);
endmodule
`default_nettype wire

/* File: logic/uart_pkg.sv */
// Shared constants, types and register map for the serial port block
`default_nettype none
package uart_pkg;
	// ****************************************************************
	// Register byte offsets and reset values
	// ****************************************************************
	localparam logic [7:0] OFF_BDH   = 8'h00;
	localparam logic [7:0] OFF_BDL   = 8'h04;
	localparam logic [7:0] OFF_CTRL1 = 8'h08;
	localparam logic [7:0] OFF_CTRL2 = 8'h0C;
	localparam logic [7:0] OFF_STAT  = 8'h10;
	localparam logic [7:0] OFF_DATA  = 8'h14;
	localparam logic [7:0] RST_BDH   = 8'h00;
	localparam logic [7:0] RST_BDL   = 8'h04;
	localparam logic [7:0] RST_CTRL  = 8'h00;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BDH_BRK_IE  = 7;
	localparam int BDH_EDGE_IE = 6;
	localparam int C1_TX_INV   = 5;
	localparam int C1_NINE     = 4;
	localparam int C1_WAKE_ADR = 3;
	localparam int C1_PAR_EN   = 1;
	localparam int C1_PAR_ODD  = 0;
	localparam int C2_TX_EN    = 3;
	localparam int C2_RX_EN    = 2;
	localparam int C2_RX_SLEEP = 1;
	localparam int C2_SEND_BRK = 0;

	// ****************************************************************
	// Cycle and bit counts
	// ****************************************************************
	localparam logic [3:0] OVS_LAST    = 4'hF;  // 16 samples per bit
	localparam logic [3:0] SMP_FIRST   = 4'h7;
	localparam logic [3:0] SMP_LAST    = 4'h9;
	localparam logic [3:0] TX_BRK_BITS = 4'hD;  // 13 bit times; the 11-bit shift register sends 11 low, then 2 high
	localparam logic [7:0] RX_BRK_TKS  = 8'hB0; // 11 bits x 16
	localparam logic [7:0] IDLE8_TKS   = 8'hA0; // 10 bits x 16
	localparam logic [7:0] IDLE9_TKS   = 8'hB0; // 11 bits x 16

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic tdre;
		logic tc;
		logic rdrf;
		logic idle;
		logic overrun;
		logic noise;
		logic framing;
		logic parity_err;
		logic rx_edge;
		logic line_break;
	} status_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_t;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} rx_state_t;
endpackage
`default_nettype wire

/* File: sim/serial_async_baud_and_frame_tb.sv */
// Self-checking bench for the serial port block
`timescale 1ns/1ps
`default_nettype none
module serial_async_baud_and_frame_tb;
	import uart_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        sys_rst_i  = 1'b1;
	logic [7:0]  paddr_i    = 8'h00;
	logic        psel_i     = 1'b0;
	logic        penable_i  = 1'b0;
	logic        pwrite_i   = 1'b0;
	logic [31:0] pwdata_i   = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        rxd_i;
	logic        txd_o;
	logic        break_irq_o;
	logic        edge_irq_o;
	int          error_cnt  = 0;
	int          tests_run  = 0;
	logic [7:0]  exp_q[$];

	always #10 core_clk_i = ~core_clk_i;

	serial_async_baud_and_frame dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_o(txd_o),
		.break_irq_o(break_irq_o), .edge_irq_o(edge_irq_o));
	serial_peer peer (.clk_i(core_clk_i), .line_i(txd_o), .line_o(rxd_i));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	// One APB transfer; waits on pready under a bound
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge core_clk_i);
		paddr_i <= a;
		pwrite_i <= w;
		pwdata_i <= d;
		psel_i <= 1'b1;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog far beyond the few thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge core_clk_i);
		error_cnt++;
		wrap_up();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  got;
		logic        ok;
		int          n;
		void'($urandom(32'h6b48));
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		apb(OFF_BDH, 1'b0, 0, r, e);
		check(r, {24'h0, RST_BDH}, "high reset");
		apb(OFF_BDL, 1'b0, 0, r, e);
		check(r, 32'h0000_0004, "low reset non-zero");
		apb(8'h40, 1'b0, 0, r, e);
		check({r[30:0], e}, 32'h0000_0001, "unmapped");
		$display("test reset done");
		// Divisor 2 gives 32 clocks per bit
		apb(OFF_BDH, 1'b1, 0, r, e);
		apb(OFF_BDL, 1'b1, 32'h0000_0002, r, e);
		apb(OFF_CTRL2, 1'b1, 32'h0000_000C, r, e);
		for (int k = 0; k < 2; k++) begin
			exp_q.push_back(8'($urandom));
			apb(OFF_DATA, 1'b1, {24'h0, exp_q[$]}, r, e);
			peer.recv(32, got, ok);
			check({ok, got}, {1'b1, exp_q.pop_front()}, "tx frame");
			// Buffered high half must not alter the rate yet
			apb(OFF_BDH, 1'b1, 32'h0000_001F, r, e);
		end
		$display("test transmit done");
		// Commit divisor 1: 16 clocks per bit both ways
		apb(OFF_BDH, 1'b1, 0, r, e);
		apb(OFF_BDL, 1'b1, 32'h0000_0001, r, e);
		exp_q.push_back(8'($urandom));
		apb(OFF_DATA, 1'b1, {24'h0, exp_q[$]}, r, e);
		peer.recv(16, got, ok);
		check({ok, got}, {1'b1, exp_q.pop_front()}, "tx after commit");
		exp_q.push_back(8'($urandom));
		peer.send(exp_q[$], 16);
		n = 0;
		do begin
			apb(OFF_STAT, 1'b0, 0, r, e);
			n++;
		end while (r[7] !== 1'b1 && n < 100);
		check({r[7], r[1]}, 32'h0000_0003, "rx full and edge flags");
		#1 check(edge_irq_o, 1'b0, "edge irq masked");
		apb(OFF_DATA, 1'b0, 0, r, e);
		check(r[8:0], {1'b0, exp_q.pop_front()}, "rx data");
		apb(OFF_BDH, 1'b1, 32'h0000_0040, r, e);
		repeat (2) @(posedge core_clk_i);
		#1 check(edge_irq_o, 1'b1, "edge irq enabled");
		apb(OFF_STAT, 1'b1, 32'h0000_0002, r, e);
		repeat (2) @(posedge core_clk_i);
		#1 check(edge_irq_o, 1'b0, "edge irq cleared");
		$display("test receive done");
		// Twelve bit times low is a break
		peer.hold_low(12 * 16);
		repeat (40) @(posedge core_clk_i);
		apb(OFF_STAT, 1'b0, 0, r, e);
		check(r[0], 1'b1, "break flag");
		#1 check(break_irq_o, 1'b0, "break irq masked");
		apb(OFF_BDH, 1'b1, 32'h0000_0080, r, e);
		repeat (2) @(posedge core_clk_i);
		#1 check(break_irq_o, 1'b1, "break irq enabled");
		$display("test break done");
		// Break left an unread zero char with a bad stop; a new char overruns it
		peer.send(8'($urandom), 16);
		repeat (200) @(posedge core_clk_i);
		apb(OFF_STAT, 1'b0, 0, r, e);
		check({r[6], r[5], r[3]}, 32'h0000_0007, "idle overrun framing");
		apb(OFF_DATA, 1'b0, 0, r, e);
		check(r[8:0], 32'h0000_0000, "overrun keeps old data");
		$display("test overrun done");
		apb(OFF_CTRL1, 1'b1, 32'h0000_0020, r, e);
		repeat (2) @(posedge core_clk_i);
		#1 check(txd_o, 1'b0, "inverted idle");
		apb(OFF_CTRL1, 1'b1, 0, r, e);
		// Divisor zero freezes the transmitter: at most the start edge
		apb(OFF_BDH, 1'b1, 0, r, e);
		apb(OFF_BDL, 1'b1, 0, r, e);
		apb(OFF_DATA, 1'b1, 32'h0000_0055, r, e);
		n = 0;
		repeat (400) begin
			got[0] = txd_o;
			@(posedge core_clk_i);
			#1 n += (txd_o !== got[0]);
		end
		check(n <= 1, 1'b1, "stopped generator");
		$display("test stop done");
		wrap_up();
	end
endmodule
`default_nettype wire

/* File: sim/serial_peer.sv */
// Remote serial port model facing the block's transmit and receive pins
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	// Idle line is high, like a pulled-up serial wire
	initial line_o = 1'b1;

	// One 8-bit frame: start, data LSB first, stop
	task automatic send(input logic [7:0] d, input int bt);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			line_o <= f[i];
			repeat (bt - 1) @(posedge clk_i);
		end
	endtask

	// Line held low for n cycles, then released
	task automatic hold_low(input int n);
		@(posedge clk_i);
		line_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		line_o <= 1'b1;
	endtask

	// Samples at mid-bit, so a wrong bit period garbles the data
	task automatic recv(input int bt, output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		while (line_i !== 1'b0 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (bt / 2) @(posedge clk_i);
		ok = (line_i === 1'b0) && (n < 2000);
		for (int i = 0; i < 8; i++) begin
			repeat (bt) @(posedge clk_i);
			d[i] = line_i;
		end
		repeat (bt) @(posedge clk_i);
		ok = ok && (line_i === 1'b1);
	endtask
endmodule
`default_nettype wire
